//--- logic/iars_defs.vh
// constants for the insulation alarm relay sequencer
`ifndef IARS_DEFS_VH
`define IARS_DEFS_VH
`define IARS_ADDR_CTRL 12'h000
`define IARS_ADDR_PREV_TH 12'h004
`define IARS_ADDR_ALM_TH 12'h008
`define IARS_ADDR_DELAY 12'h00c
`define IARS_ADDR_RES 12'h010
`define IARS_ADDR_STATUS 12'h014
`define IARS_ADDR_IRQ_STAT 12'h018
`define IARS_ADDR_IRQ_MASK 12'h01c
`define IARS_CTRL_RELEASE_BIT 0
`define IARS_CTRL_CORR_BIT 1
`define IARS_CTRL_RESET 2'h0
`define IARS_PREV_TH_RESET 32'h0000c350
`define IARS_ALM_TH_RESET 32'h00002710
`define IARS_DELAY_RESET 32'h00000001
`define IARS_CLK_HZ 125000000
`define IARS_PULSE_MS 3000
`define IARS_PULSE_CYCLES (`IARS_CLK_HZ / 1000 * `IARS_PULSE_MS)
`define IARS_ST_NORMAL 3'h0
`define IARS_ST_CONFIRM 3'h1
`define IARS_ST_ALARM 3'h2
`define IARS_ST_ACKED 3'h3
`define IARS_ST_CORR 3'h4
`endif

//--- logic/iars_sync.v
// two flip-flop synchroniser for a pin level
`timescale 1ns/10ps
module iars_sync (
	input wire clk,
	input wire rst_n,
	input wire din,
	output wire dout
);
	reg s1_q;
	reg s2_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
		end
	end
	assign dout = s2_q;
endmodule

//--- logic/iars_timer.v
// loadable down counter that flags expiry
`timescale 1ns/10ps
module iars_timer #(
	parameter W = 32
) (
	input wire clk,
	input wire rst_n,
	input wire start,
	input wire stop,
	input wire [W-1:0] load,
	output wire running,
	output wire done
);
	reg [W-1:0] cnt_q;
	reg run_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {W{1'b0}};
			run_q <= 1'b0;
		end else if (stop) begin
			cnt_q <= {W{1'b0}};
			run_q <= 1'b0;
		end else if (start) begin
			cnt_q <= load;
			run_q <= 1'b1;
		end else if (run_q) begin
			if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
				run_q <= 1'b0;
				cnt_q <= {W{1'b0}};
			end else begin
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
	assign running = run_q;
	assign done = run_q && (cnt_q <= {{(W-1){1'b0}}, 1'b1}) && !stop && !start;
endmodule

//--- logic/iars_top.v
// insulation alarm relay sequencer with apb registers
// Overview of operation
// - resistance below preventive threshold sets preventive relay
// - fault waits confirmation delay, then alarm relay
// - acknowledge with release enabled idles both relays
// - corrected fault pulses alarm relay three seconds
// - pulse option is on/off, resets off
// - pulse option honoured only with release on
// - release disabled: acknowledge keeps relays until cleared
`timescale 1ns/10ps
`include "iars_defs.vh"
module iars_top #(
	parameter PULSE_CYCLES = `IARS_PULSE_CYCLES
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire ack_button,
	output reg prev_relay,
	output reg alarm_relay,
	output wire irq
);
	reg [1:0] ctrl_q;
	reg [31:0] prev_th_q;
	reg [31:0] alm_th_q;
	reg [31:0] delay_q;
	reg [31:0] res_q;
	reg [3:0] irq_stat_q;
	reg [3:0] irq_mask_q;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg ack_d1_q;
	wire ack_sync;
	wire ack_press;
	wire wr_en;
	wire rd_en;
	wire addr_ok;
	wire release_en;
	wire corr_en;
	wire below_prev;
	wire below_alm;
	wire conf_start;
	wire conf_stop;
	wire conf_done;
	wire conf_run;
	wire pulse_start;
	wire pulse_done;
	wire pulse_run;
	wire [3:0] ev;
	reg prev_relay_d;
	reg alarm_relay_d;
	// read path, events and state decode
	reg [31:0] rdata_d;
	reg [3:0] irq_stat_d;
	wire [31:0] status_word;
	wire [31:0] conf_load;
	wire rd_setup;
	wire fault_cleared;
	wire ack_in_alarm;
	wire ev_prev;
	wire ev_alarm;
	wire ev_ack;
	wire ev_clear;
	wire in_normal;
	wire in_confirm;
	wire in_alarm;
	wire in_acked;
	wire in_corr;
	localparam [31:0] PULSE_LOAD = PULSE_CYCLES;

	// apb decode
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !pwrite;
	assign rd_setup = rd_en && !penable;
	// zero wait states: every access ends in its first access cycle
	assign pready = 1'b1;
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `IARS_ADDR_IRQ_MASK);
	assign pslverr = psel && penable && !addr_ok;

	assign release_en = ctrl_q[`IARS_CTRL_RELEASE_BIT];
	assign corr_en = ctrl_q[`IARS_CTRL_CORR_BIT] && release_en;
	assign below_prev = res_q < prev_th_q;
	assign below_alm = res_q < alm_th_q;

	// state decode shared by the timers and events; relay drive decodes state_d
	assign in_normal = (state_q == `IARS_ST_NORMAL);
	assign in_confirm = (state_q == `IARS_ST_CONFIRM);
	assign in_alarm = (state_q == `IARS_ST_ALARM);
	assign in_acked = (state_q == `IARS_ST_ACKED);
	assign in_corr = (state_q == `IARS_ST_CORR);

	// acknowledge pin is asynchronous: two flip-flops before use
	iars_sync u_ack_sync (
		.clk(pclk),
		.rst_n(presetn),
		.din(ack_button),
		.dout(ack_sync)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_d1_q <= 1'b0;
		end else begin
			ack_d1_q <= ack_sync;
		end
	end
	// a press is the rising edge of the synchronised level
	assign ack_press = ack_sync && !ack_d1_q;

	// registers
	// unmapped offsets and the status word ignore writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `IARS_CTRL_RESET;
			prev_th_q <= `IARS_PREV_TH_RESET;
			alm_th_q <= `IARS_ALM_TH_RESET;
			delay_q <= `IARS_DELAY_RESET;
			res_q <= 32'hffffffff;
			irq_mask_q <= 4'h0;
		end else if (wr_en) begin
			case (paddr)
			`IARS_ADDR_CTRL: ctrl_q <= pwdata[1:0];
			`IARS_ADDR_PREV_TH: prev_th_q <= pwdata;
			`IARS_ADDR_ALM_TH: alm_th_q <= pwdata;
			`IARS_ADDR_DELAY: delay_q <= pwdata;
			`IARS_ADDR_RES: res_q <= pwdata;
			`IARS_ADDR_IRQ_MASK: irq_mask_q <= pwdata[3:0];
			default: ;
			endcase
		end
	end

	// events: preventive entry, alarm entry, acknowledge, fault cleared
	assign fault_cleared = (in_alarm || in_acked) && !below_alm;
	assign ack_in_alarm = in_alarm && ack_press;
	assign ev_prev = below_prev && !prev_relay;
	assign ev_alarm = !in_alarm && (state_d == `IARS_ST_ALARM);
	assign ev_ack = ack_in_alarm;
	assign ev_clear = fault_cleared;
	assign ev = {ev_clear, ev_ack, ev_alarm, ev_prev};

	// set wins over write-one-to-clear
	always @* begin
		irq_stat_d = irq_stat_q;
		if (wr_en && paddr == `IARS_ADDR_IRQ_STAT) begin
			irq_stat_d = irq_stat_q & ~pwdata[3:0];
		end
		// clear first, so a same-cycle event survives
		irq_stat_d = irq_stat_d | ev;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 4'h0;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end
	// level interrupt from any unmasked event
	assign irq = |(irq_stat_q & irq_mask_q);

	// status word: timers, relays, state
	assign status_word = {25'h0, conf_run, pulse_run, alarm_relay, prev_relay, state_q};

	always @* begin
		case (paddr)
		`IARS_ADDR_CTRL: rdata_d = {30'h0, ctrl_q};
		`IARS_ADDR_PREV_TH: rdata_d = prev_th_q;
		`IARS_ADDR_ALM_TH: rdata_d = alm_th_q;
		`IARS_ADDR_DELAY: rdata_d = delay_q;
		`IARS_ADDR_RES: rdata_d = res_q;
		`IARS_ADDR_STATUS: rdata_d = status_word;
		`IARS_ADDR_IRQ_STAT: rdata_d = {28'h0, irq_stat_q};
		`IARS_ADDR_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
		default: rdata_d = 32'h0;
		endcase
	end

	// read word captured in the setup cycle, held through access, else zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			prdata <= rdata_d;
		end else if (!(rd_en && penable)) begin
			prdata <= 32'h0;
		end
	end

	// confirmation and corrected-fault timers
	// a zero delay behaves as one cycle
	assign conf_load = (delay_q == 32'h0) ? 32'h00000001 : delay_q;
	assign conf_start = in_normal && below_alm;
	assign conf_stop = in_confirm && !below_alm;
	iars_timer #(.W(32)) u_conf (
		.clk(pclk),
		.rst_n(presetn),
		.start(conf_start),
		.stop(conf_stop),
		.load(conf_load),
		.running(conf_run),
		.done(conf_done)
	);

	// corrected-fault pulse timer
	assign pulse_start = !in_corr && (state_d == `IARS_ST_CORR);
	iars_timer #(.W(32)) u_pulse (
		.clk(pclk),
		.rst_n(presetn),
		.start(pulse_start),
		.stop(1'b0),
		.load(PULSE_LOAD),
		.running(pulse_run),
		.done(pulse_done)
	);

	// alarm sequencing
	always @* begin
		state_d = state_q;
		case (state_q)
		`IARS_ST_NORMAL: begin
			if (below_alm) begin
				state_d = `IARS_ST_CONFIRM;
			end
		end
		`IARS_ST_CONFIRM: begin
			if (!below_alm) begin
				state_d = `IARS_ST_NORMAL;
			end else if (conf_done) begin
				state_d = `IARS_ST_ALARM;
			end
		end
		// acknowledge releases only when release is enabled
		`IARS_ST_ALARM: begin
			if (!below_alm) begin
				state_d = corr_en ? `IARS_ST_CORR : `IARS_ST_NORMAL;
			end else if (ack_press && release_en) begin
				state_d = `IARS_ST_ACKED;
			end
		end
		// a cleared fault may pulse the alarm relay
		`IARS_ST_ACKED: begin
			if (!below_alm) begin
				state_d = corr_en ? `IARS_ST_CORR : `IARS_ST_NORMAL;
			end
		end
		// the pulse always runs to its end
		`IARS_ST_CORR: begin
			if (pulse_done) begin
				state_d = `IARS_ST_NORMAL;
			end
		end
		default: state_d = `IARS_ST_NORMAL;
		endcase
	end

	// relay levels for the state being entered
	always @* begin
		prev_relay_d = below_prev;
		alarm_relay_d = 1'b0;
		case (state_d)
		`IARS_ST_ALARM: alarm_relay_d = 1'b1;
		`IARS_ST_ACKED: prev_relay_d = 1'b0;
		`IARS_ST_CORR: alarm_relay_d = 1'b1;
		default: ;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= `IARS_ST_NORMAL;
		end else begin
			state_q <= state_d;
		end
	end

	// preventive relay
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_relay <= 1'b0;
		end else begin
			prev_relay <= prev_relay_d;
		end
	end

	// insulation alarm relay
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_relay <= 1'b0;
		end else begin
			alarm_relay <= alarm_relay_d;
		end
	end
endmodule

//--- test/iars_checker.sv
// port assertions for the relay sequencer
`timescale 1ns/10ps
`include "iars_defs.vh"
module iars_checker #(
	parameter PULSE_CYCLES = 20
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire ack_button,
	input wire prev_relay,
	input wire alarm_relay,
	input wire irq
);
	reg [31:0] res_q;
	reg [1:0] ctrl_q;
	int hi_q;
	wire wr = psel && penable && pwrite;
	wire flt = res_q < `IARS_ALM_TH_RESET;
	// shadow of the writes that steer the relays
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_q <= 32'hffffffff;
			ctrl_q <= 2'h0;
			hi_q <= 0;
		end else begin
			if (wr && paddr == `IARS_ADDR_RES) res_q <= pwdata;
			if (wr && paddr == `IARS_ADDR_CTRL) ctrl_q <= pwdata[1:0];
			hi_q <= (alarm_relay && !flt) ? hi_q + 1 : 0;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_prev; prev_relay |-> $past(res_q) < `IARS_PREV_TH_RESET; endproperty
	a_prev: assert property (p_prev) else $error("prev relay without low level");
	property p_conf; $rose(alarm_relay) && ctrl_q != 2'h3 |-> $past(flt, 2); endproperty
	a_conf: assert property (p_conf) else $error("alarm relay before delay");
	property p_rel; $rose(ack_button) && alarm_relay && flt && ctrl_q[0]
		|-> ##[2:8] !alarm_relay && !prev_relay; endproperty
	a_rel: assert property (p_rel) else $error("ack did not idle relays");
	property p_len; $fell(alarm_relay) && !flt && ctrl_q == 2'h3
		|-> hi_q >= PULSE_CYCLES - 1 && hi_q <= PULSE_CYCLES + 2; endproperty
	a_len: assert property (p_len) else $error("cleared pulse length wrong");
	property p_only; alarm_relay && !flt && $past(!flt, 3) |-> ctrl_q == 2'h3; endproperty
	a_only: assert property (p_only) else $error("pulse without both options");
	property p_keep; $rose(ack_button) && alarm_relay && flt && !ctrl_q[0]
		|-> ##1 alarm_relay [*8]; endproperty
	a_keep: assert property (p_keep) else $error("ack dropped relay");
	property p_rdy; psel && penable |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low in access");
	property p_err; psel && penable && paddr > 12'h01c |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no error on unmapped");
	c_alarm: cover property ($rose(alarm_relay));
	c_err: cover property (pslverr);
	c_pulse: cover property ($fell(alarm_relay) && !flt);
endmodule

//--- test/iars_relay_model.sv
// relay loads: time each alarm relay activation
`timescale 1ns/10ps
module iars_relay_model (
	input wire pclk,
	input wire alarm_relay,
	input wire prev_relay,
	output int pulse_len
);
	int run = 0;
	initial pulse_len = 0;
	always @(posedge pclk) begin
		if (alarm_relay) begin
			run <= run + 1;
		end else if (run != 0) begin
			pulse_len <= run;
			run <= 0;
		end
	end
endmodule

//--- test/tb_top.sv
// self-checking bench for the relay sequencer
`timescale 1ns/10ps
`include "iars_defs.vh"
module tb_top;
	localparam P = 20;
	reg pclk = 0;
	reg presetn = 0;
	reg psel = 0;
	reg penable = 0;
	reg pwrite = 0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h00000000;
	reg ack_button = 0;
	wire [31:0] prdata;
	wire pready, pslverr, prev_relay, alarm_relay, irq;
	int pulse_len, failures = 0, comparisons = 0;
	reg [31:0] rd;
	reg err;
	always #4 pclk = ~pclk;
	iars_top #(.PULSE_CYCLES(P)) iars_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ack_button(ack_button),
		.prev_relay(prev_relay), .alarm_relay(alarm_relay), .irq(irq));
	iars_relay_model iars_relay_model_i (.pclk(pclk), .alarm_relay(alarm_relay),
		.prev_relay(prev_relay), .pulse_len(pulse_len));
	task chk(input string n, input [31:0] s, input [31:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task apb(input bit w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wait_al(input bit v);
		for (int i = 0; i < 60 && alarm_relay !== v; i++) @(posedge pclk);
	endtask
	task press;
		@(posedge pclk) ack_button <= 1;
		repeat (4) @(posedge pclk);
		ack_button <= 0;
		repeat (10) @(posedge pclk);
	endtask
	task t_reset;
		chk("relays", {prev_relay, alarm_relay}, 0);
		apb(0, `IARS_ADDR_CTRL, 0);
		chk("ctrl", rd, 0);
		apb(0, `IARS_ADDR_RES, 0);
		chk("res", rd, 32'hffffffff);
		$display("test reset done");
	endtask
	task t_prev;
		apb(1, `IARS_ADDR_IRQ_MASK, 1);
		apb(1, `IARS_ADDR_RES, 32'h0000c34f);
		repeat (4) @(posedge pclk);
		chk("prev", prev_relay, 1);
		chk("alarm", alarm_relay, 0);
		chk("irq", irq, 1);
		apb(1, `IARS_ADDR_IRQ_STAT, 1);
		@(posedge pclk);
		chk("irq clr", irq, 0);
		apb(1, `IARS_ADDR_RES, 32'h0000c350);
		repeat (4) @(posedge pclk);
		chk("prev off", prev_relay, 0);
		$display("test preventive done");
	endtask
	task t_keep;
		apb(1, `IARS_ADDR_CTRL, 2);
		apb(1, `IARS_ADDR_RES, 32'h0000270f);
		chk("delay", alarm_relay, 0);
		wait_al(1);
		chk("alarm", alarm_relay, 1);
		press;
		chk("kept", {prev_relay, alarm_relay}, 3);
		apb(1, `IARS_ADDR_RES, 32'h00002710);
		repeat (P + 10) @(posedge pclk);
		chk("no pulse", alarm_relay, 0);
		$display("test release off done");
	endtask
	task t_pulse;
		apb(1, `IARS_ADDR_CTRL, 3);
		apb(1, `IARS_ADDR_RES, 32'h000001f4);
		wait_al(1);
		press;
		chk("released", {prev_relay, alarm_relay}, 0);
		apb(1, `IARS_ADDR_RES, 32'h00010000);
		wait_al(1);
		wait_al(0);
		repeat (2) @(posedge pclk);
		chk("pulse", pulse_len, P);
		$display("test corrected pulse done");
	endtask
	task t_bus;
		apb(1, 12'h020, 32'h00000001);
		chk("wr err", err, 1);
		apb(0, 12'h020, 0);
		chk("rd err", err, 1);
		chk("rd data", rd, 0);
		$display("test bus done");
	endtask
	task end_sim;
		$display("checks %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		t_reset;
		t_prev;
		t_keep;
		t_pulse;
		t_bus;
		end_sim;
	end
	initial begin
		#40000;
		failures++;
		end_sim;
	end
endmodule
bind iars_top iars_checker #(.PULSE_CYCLES(PULSE_CYCLES)) iars_checker_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ack_button(ack_button), .prev_relay(prev_relay), .alarm_relay(alarm_relay), .irq(irq));
